// file: rtl/ssr_pkg.sv
// Package: constants, register map and types of the synchronous serial receiver
// Behaviour
// RQ1: Synchronous master receive turns the data pin driver off.
// RQ2: Synchronous reception starts only when single or continuous receive enable is set.
// RQ3: Single receive as master makes one character of clocks, then clears itself.
// RQ4: Continuous receive as master keeps clocking until software clears it.
// RQ5: Clearing continuous receive mid-character stops the clock and drops the partial character.
// RQ6: With both enables set, single clears after the first character.
// RQ7: Data pin is sampled on the trailing clock edge into the shift register.
// RQ8: A complete character sets the receive flag and enters the two-entry buffer.
// RQ9: The receive flag stays set while any unread character remains.
// RQ10: Slave mode takes the clock from the clock pin, driver off.
// RQ11: Data changes on the leading edge, one bit per clock cycle.
// RQ12: An external master should give only as many clocks as data bits.
// RQ13: A third character with two buffered sets overrun and keeps both entries.
// RQ14: Under overrun both entries stay readable, no new character accepted.
// RQ15: Overrun under single receive clears on reading receive data.
// RQ16: Overrun under continuous receive clears on clearing continuous or port enable.
// RQ17: Nine-bit select shifts nine bits per character.
// RQ18: Ninth received bit shows the oldest character's top bit, read first.
// RQ19: Transmit control bit 1 reads shift-register-empty, resets to 1.
// RQ20: Port enable switches the port on and makes the clock pin an output; the code enables the clock pin driver only as master.
// RQ21: In synchronous mode an active receive enable overrides transmit enable.
package ssr_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ssr_off_tx_status = 8'h00;
    localparam logic [7:0] ssr_off_rx_status = 8'h04;
    localparam logic [7:0] ssr_off_rx_data = 8'h08;
    localparam logic [7:0] ssr_off_baud = 8'h0c;
    // ==========================================================
    // Field positions
    localparam int ssr_tx_clock_source_select = 7;
    localparam int ssr_tx_nine_bit_transmit_select = 6;
    localparam int ssr_tx_transmit_enable = 5;
    localparam int ssr_tx_sync = 4;
    localparam int ssr_tx_break_send_request = 3;
    localparam int ssr_tx_high_speed_baud_select = 2;
    localparam int ssr_tx_shift_reg_empty_flag = 1;
    localparam int ssr_tx_ninth_transmit_bit = 0;
    localparam int ssr_rx_serial_port_enable = 7;
    localparam int ssr_rx_nine_bit_receive_select = 6;
    localparam int ssr_rx_single_receive_enable = 5;
    localparam int ssr_rx_continuous_receive_enable = 4;
    localparam int ssr_rx_overrun_error_flag = 1;
    localparam int ssr_rx_ninth_received_bit = 0;
    localparam int ssr_rx_receive_char_flag = 8;
    // ==========================================================
    // Reset values
    localparam logic [7:0] ssr_tx_status_reset = 8'h00;
    localparam logic [7:0] ssr_rx_status_reset = 8'h00;
    localparam logic [15:0] ssr_baud_reset = 16'h0004;
    localparam logic [1:0] ssr_resp_okay = 2'h0;
    localparam logic [1:0] ssr_resp_slverr = 2'h2;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ssr_idle_state = 3'h1,
        ssr_low_state = 3'h2,
        ssr_high_state = 3'h4
    } ssr_state_type;
    typedef struct packed {
        logic bit8;
        logic [7:0] low;
    } ssr_char_type;
    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic data_oe;
    } ssr_pins_type;
endpackage : ssr_pkg

// file: rtl/ssr_receiver.sv
// Synchronous serial receiver with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ssr_receiver #(
    parameter int depth = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clock_pin_i,
    output logic clock_pin_o,
    output logic clock_pin_oe,
    input wire logic data_pin_i,
    output logic data_pin_o,
    output logic data_pin_oe,
    output logic receive_char_flag
);
    // ==========================================================
    // Registers
    logic [7:0] tx_status;
    logic serial_port_enable;
    logic nine_bit_receive_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic overrun_error_flag;
    logic overrun_single;
    logic [15:0] baud;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic rd_fire;
    logic rd_data_pop;
    logic master_mode;
    logic sync_mode;
    logic rx_active;
    // ==========================================================
    // Link side
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic clk_prev;
    ssr_pkg::ssr_state_type state;
    logic [15:0] baud_cnt;
    logic master_clk;
    logic [8:0] receive_shift_reg;
    logic [3:0] bit_cnt;
    logic sample_edge;
    logic char_done;
    ssr_pkg::ssr_char_type buffer [depth];
    logic [1:0] count;
    logic head;
    logic push;
    ssr_pkg::ssr_pins_type pins;

    assign sync_mode = tx_status[ssr_pkg::ssr_tx_sync];
    assign master_mode = tx_status[ssr_pkg::ssr_tx_clock_source_select];
    assign rx_active = serial_port_enable && sync_mode &&
                       (single_receive_enable || continuous_receive_enable); // [RQ2] [RQ21]
    // ==========================================================
    // AXI4-Lite write
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ssr_pkg::ssr_resp_okay;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == ssr_pkg::ssr_off_tx_status || aw_addr == ssr_pkg::ssr_off_rx_status ||
                            aw_addr == ssr_pkg::ssr_off_baud) ? ssr_pkg::ssr_resp_okay : ssr_pkg::ssr_resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    // ==========================================================
    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_status <= ssr_pkg::ssr_tx_status_reset;
            baud <= ssr_pkg::ssr_baud_reset;
        end else if (wr_fire && w_strb[0] && aw_addr == ssr_pkg::ssr_off_tx_status) begin
            tx_status <= w_data[7:0];
        end else if (wr_fire && aw_addr == ssr_pkg::ssr_off_baud) begin
            if (w_strb[0]) begin
                baud[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                baud[15:8] <= w_data[15:8];
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_port_enable <= 1'b0;
            nine_bit_receive_select <= 1'b0;
            single_receive_enable <= 1'b0;
            continuous_receive_enable <= 1'b0;
        end else if (wr_fire && w_strb[0] && aw_addr == ssr_pkg::ssr_off_rx_status) begin
            serial_port_enable <= w_data[ssr_pkg::ssr_rx_serial_port_enable]; // [RQ20]
            nine_bit_receive_select <= w_data[ssr_pkg::ssr_rx_nine_bit_receive_select];
            single_receive_enable <= w_data[ssr_pkg::ssr_rx_single_receive_enable];
            continuous_receive_enable <= w_data[ssr_pkg::ssr_rx_continuous_receive_enable];
        end else if (!serial_port_enable) begin
            single_receive_enable <= 1'b0;
        end else if (char_done && master_mode) begin
            single_receive_enable <= 1'b0; // [RQ3] [RQ6]
        end
    end
    // ==========================================================
    // AXI4-Lite read
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
    assign rd_data_pop = rd_fire && s_axi_araddr == ssr_pkg::ssr_off_rx_data && count != 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ssr_pkg::ssr_resp_okay;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ssr_pkg::ssr_resp_okay;
            case (s_axi_araddr)
                ssr_pkg::ssr_off_tx_status: begin
                    s_axi_rdata <= {24'h000000, tx_status[7:2], 1'b1, tx_status[0]}; // [RQ19]
                end
                ssr_pkg::ssr_off_rx_status: begin
                    s_axi_rdata <= {23'h000000, receive_char_flag, serial_port_enable, nine_bit_receive_select,
                                    single_receive_enable, continuous_receive_enable, 2'h0,
                                    overrun_error_flag, buffer[head].bit8 && receive_char_flag}; // [RQ18]
                end
                ssr_pkg::ssr_off_rx_data: begin
                    s_axi_rdata <= {24'h000000, buffer[head].low}; // [RQ8]
                end
                ssr_pkg::ssr_off_baud: begin
                    s_axi_rdata <= {16'h0000, baud};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= ssr_pkg::ssr_resp_slverr;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_sync <= 2'h0;
            dat_sync <= 2'h0;
            clk_prev <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], clock_pin_i};
            dat_sync <= {dat_sync[0], data_pin_i};
            clk_prev <= clk_sync[1];
        end
    end
    // ==========================================================
    // Master clock generator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ssr_pkg::ssr_idle_state;
            baud_cnt <= 16'h0000;
            master_clk <= 1'b0;
        end else if (!(rx_active && master_mode) || overrun_error_flag) begin
            state <= ssr_pkg::ssr_idle_state; // [RQ5] [RQ14]
            baud_cnt <= 16'h0000;
            master_clk <= 1'b0;
        end else begin
            case (state)
                ssr_pkg::ssr_idle_state: begin
                    state <= ssr_pkg::ssr_low_state;
                    baud_cnt <= baud;
                end
                ssr_pkg::ssr_low_state: begin
                    if (baud_cnt == 16'h0000) begin
                        state <= ssr_pkg::ssr_high_state; // [RQ11]
                        master_clk <= 1'b1;
                        baud_cnt <= baud;
                    end else begin
                        baud_cnt <= baud_cnt - 16'h0001;
                    end
                end
                ssr_pkg::ssr_high_state: begin
                    if (baud_cnt == 16'h0000) begin
                        master_clk <= 1'b0;
                        baud_cnt <= baud;
                        state <= (char_done && !continuous_receive_enable) ? ssr_pkg::ssr_idle_state
                                 : ssr_pkg::ssr_low_state; // [RQ3] [RQ4]
                    end else begin
                        baud_cnt <= baud_cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= ssr_pkg::ssr_idle_state;
                end
            endcase
        end
    end
    assign sample_edge = master_mode ? (state == ssr_pkg::ssr_high_state && baud_cnt == 16'h0000)
                                     : (clk_prev && !clk_sync[1]); // [RQ7] [RQ10]
    // ==========================================================
    // Shift register
    assign char_done = rx_active && sample_edge &&
                       (bit_cnt == (nine_bit_receive_select ? 4'h8 : 4'h7)); // [RQ17]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            receive_shift_reg <= 9'h000;
            bit_cnt <= 4'h0;
        end else if (!rx_active || overrun_error_flag) begin
            bit_cnt <= 4'h0; // [RQ5]
        end else if (sample_edge) begin
            receive_shift_reg <= {dat_sync[1], receive_shift_reg[8:1]}; // [RQ7]
            bit_cnt <= char_done ? 4'h0 : bit_cnt + 4'h1;
        end
    end
    // ==========================================================
    // Receive buffer
    assign push = char_done && count != 2'(depth) && !overrun_error_flag;
    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_port_enable) begin
            count <= 2'h0;
            head <= 1'b0;
        end else begin
            count <= count + 2'(push) - 2'(rd_data_pop);
            if (rd_data_pop) begin
                head <= !head;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (push) begin
            buffer[head ^ count[0]] <= nine_bit_receive_select
                ? ssr_pkg::ssr_char_type'({dat_sync[1], receive_shift_reg[8:1]})
                : ssr_pkg::ssr_char_type'({1'b0, dat_sync[1], receive_shift_reg[8:2]}); // [RQ8]
        end
    end
    assign receive_char_flag = count != 2'h0; // [RQ9]
    // ==========================================================
    // Overrun
    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_port_enable) begin
            overrun_error_flag <= 1'b0; // [RQ16]
            overrun_single <= 1'b0;
        end else if (char_done && count == 2'(depth)) begin
            overrun_error_flag <= 1'b1; // [RQ13]
            overrun_single <= !continuous_receive_enable;
        end else if (overrun_single ? rd_data_pop : !continuous_receive_enable) begin
            overrun_error_flag <= 1'b0; // [RQ15] [RQ16]
        end
    end
    // ==========================================================
    // Pins
    always_comb begin
        pins.clk_o = master_clk;
        pins.clk_oe = serial_port_enable && master_mode; // [RQ10] [RQ20]
        pins.data_oe = serial_port_enable && !(sync_mode && rx_active) &&
                       tx_status[ssr_pkg::ssr_tx_transmit_enable]; // [RQ1] [RQ21]
    end
    assign clock_pin_o = pins.clk_o;
    assign clock_pin_oe = pins.clk_oe;
    assign data_pin_o = 1'b1;
    assign data_pin_oe = pins.data_oe;
endmodule : ssr_receiver
`default_nettype wire

// file: sim/ssr_asserts.sv
// Checker: port-level properties of the synchronous serial receiver
`timescale 1ns/1ps
`default_nettype none
module ssr_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clock_pin_o,
    input wire logic clock_pin_oe,
    input wire logic data_pin_oe,
    input wire logic receive_char_flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [3:0] quiet;
    // ==========================================================
    // Cycles since the last register access
    always_ff @(posedge aclk) begin
        if (!aresetn || (s_axi_arvalid && s_axi_arready) || (s_axi_awvalid && s_axi_awready)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end
    sequence ar_take;
        s_axi_arvalid && s_axi_arready && !s_axi_rvalid;
    endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // ==========================================================
    // Properties
    read_answer_a: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
    write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    bad_read_a: assert property (ar_take ##0 (s_axi_araddr > 8'h0c) |=>
        s_axi_rresp == ssr_pkg::ssr_resp_slverr && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    bad_write_a: assert property (wr_take ##0 (s_axi_awaddr == ssr_pkg::ssr_off_rx_data) |->
        ##2 s_axi_bresp == ssr_pkg::ssr_resp_slverr) else $error("data register write accepted");
    tx_empty_a: assert property (ar_take ##0 (s_axi_araddr == ssr_pkg::ssr_off_tx_status) |=>
        s_axi_rdata[1]) else $error("shift empty flag low");
    rx_driver_off_a: assert property (clock_pin_oe && $rose(clock_pin_o) |-> !data_pin_oe)
        else $error("data driver on while receiving");
    low_phase_a: assert property ($fell(clock_pin_o) |-> !clock_pin_o [*5])
        else $error("clock low phase short");
    flag_hold_a: assert property ($fell(receive_char_flag) |-> quiet < 4'h5)
        else $error("receive flag dropped unread");
endmodule : ssr_asserts
`default_nettype wire

// file: sim/ssr_peer.sv
// Peer model: far-side synchronous serial device on clock and data lines
`timescale 1ns/1ps
`default_nettype none
module ssr_peer (
    input wire logic line_clk,
    input wire logic dev_clk_oe,
    output logic sclk,
    output logic sdata
);
    logic [8:0] words[$];
    logic [8:0] cur;
    logic act;
    int nbits = 8;
    int idx = 0;
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        act = 1'b0;
    end
    // ==========================================================
    // Leading edge puts out the next bit, lsb first; idle line toggles
    task automatic lead;
        if (idx == 0) begin
            act = words.size() > 0;
            if (act) cur = words.pop_front();
        end
        sdata = act ? cur[idx] : ~sdata;
        idx = (idx + 1) % nbits;
    endtask : lead
    always @(posedge line_clk) begin
        if (dev_clk_oe) begin
            lead();
        end
    end
    // Slave clocking: one 80 ns clock per data bit, low between frames
    task automatic drive(input int n);
        repeat (n) begin
            #40 sclk = 1'b1;
            lead();
            #40 sclk = 1'b0;
        end
    endtask : drive
endmodule : ssr_peer
`default_nettype wire

// file: sim/sync_serial_receiver_test.sv
// Testbench: register traffic and serial link scenarios of the receiver
`timescale 1ns/1ps
`default_nettype none
`define check(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module sync_serial_receiver_test;
    localparam logic [7:0] ta = ssr_pkg::ssr_off_tx_status;
    localparam logic [7:0] ra = ssr_pkg::ssr_off_rx_status;
    localparam logic [7:0] da = ssr_pkg::ssr_off_rx_data;
    localparam logic [1:0] ok = 2'h0;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, receive_char_flag, cprev, psclk, psdata;
    logic clock_pin_o, clock_pin_oe, data_pin_o, data_pin_oe;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] exp_q[$], msk_q[$], gv, mv, ev;
    logic [8:0] w[9];
    int miscompares = 0;
    int n_compared = 0;
    int n_edges = 0;
    int e0 = 0;
    wire logic clk_line = clock_pin_oe ? clock_pin_o : psclk;
    wire logic dat_line = data_pin_oe ? data_pin_o : psdata;
    ssr_receiver #(.depth(2)) i_ssr_receiver (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .clock_pin_i(clk_line), .clock_pin_o, .clock_pin_oe, .data_pin_i(dat_line), .data_pin_o, .data_pin_oe,
        .receive_char_flag);
    ssr_peer peer (.line_clk(clk_line), .dev_clk_oe(clock_pin_oe), .sclk(psclk), .sdata(psdata));
    always #2 aclk = ~aclk;
    // ==========================================================
    // Master clock edge count and response checker
    always @(posedge aclk) begin
        cprev <= clock_pin_o;
        if (clock_pin_o && !cprev) n_edges++;
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            gv = s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
            mv = msk_q.pop_front();
            ev = exp_q.pop_front() & mv;
            `check(gv & mv, ev)
        end
    end
    // ==========================================================
    // Bus tasks and waits
    task automatic end_of_test;
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic hang;
        miscompares++;
        end_of_test();
    endtask : hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        exp_q.push_back({r, 32'h0});
        msk_q.push_back({2'h3, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) hang();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] e, input logic [31:0] m);
        int n;
        exp_q.push_back({r, e});
        msk_q.push_back({2'h3, m});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= s_axi_rvalid;
        end
        rdat = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (n == 50) hang();
    endtask : rd
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        for (n = 0; n < 200; n++) begin
            rd(ra, ok, 32'h0, 32'h0);
            if ((rdat & m) === v) break;
        end
        if (n == 200) hang();
    endtask : poll
    task automatic await(input int k);
        int n;
        for (n = 0; n < 3000; n++) begin
            if (k == 0 ? receive_char_flag === 1'b1 : n_edges - e0 >= k) break;
            @(posedge aclk);
        end
        if (n == 3000) hang();
    endtask : await
    // ==========================================================
    // Scenarios
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, aresetn} = '0;
        s_axi_wstrb = 4'hf;
        void'($urandom(56073));
        foreach (w[i]) w[i] = 9'($urandom);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ta, ok, 32'h2, 32'hff);
        wr(ta, 32'h0, ok);
        rd(ta, ok, 32'h2, 32'hff);
        rd(ra, ok, 32'h0, 32'h1ff);
        rd(8'h10, 2'h2, 32'h0, 32'hffffffff);
        wr(da, 32'h0, 2'h2);
        wr(ta, 32'hb0, ok);
        wr(ra, 32'h80, ok);
        e0 = n_edges;
        repeat (40) @(posedge aclk);
        `check(n_edges - e0, 0)
        `check(clock_pin_oe, 1'b1)
        `check(data_pin_oe, 1'b1)
        peer.words.push_back(w[8]);
        wr(ra, 32'h90, ok);
        `check(data_pin_oe, 1'b0)
        await(3);
        wr(ra, 32'h80, ok);
        e0 = n_edges;
        repeat (40) @(posedge aclk);
        `check(n_edges - e0, 0)
        rd(ra, ok, 32'h80, 32'h1fe);
        peer.idx = 0;
        peer.words.push_back(w[3]);
        e0 = n_edges;
        wr(ra, 32'ha0, ok);
        await(0);
        rd(ra, ok, 32'h180, 32'h1fe);
        rd(da, ok, 32'(w[3][7:0]), 32'hff);
        rd(ra, ok, 32'h80, 32'h1fe);
        `check(n_edges - e0, 8)
        for (int i = 0; i < 3; i++) begin
            peer.words.push_back(w[i]);
            wr(ra, 32'ha0, ok);
            poll(32'h20, 32'h0);
        end
        rd(ra, ok, 32'h182, 32'h1fe);
        rd(da, ok, 32'(w[0][7:0]), 32'hff);
        rd(ra, ok, 32'h180, 32'h1fe);
        rd(da, ok, 32'(w[1][7:0]), 32'hff);
        rd(ra, ok, 32'h80, 32'h1fe);
        peer.nbits = 9;
        for (int i = 4; i < 7; i++) peer.words.push_back(w[i]);
        e0 = n_edges;
        wr(ra, 32'hf0, ok);
        poll(32'h2, 32'h2);
        rd(ra, ok, 32'h1d2 | w[4][8], 32'h1ff);
        rd(da, ok, 32'(w[4][7:0]), 32'hff);
        rd(ra, ok, 32'h1d2 | w[5][8], 32'h1ff);
        repeat (100) @(posedge aclk);
        `check(n_edges - e0, 27)
        wr(ra, 32'hc0, ok);
        rd(ra, ok, 32'h1c0 | w[5][8], 32'h1ff);
        rd(da, ok, 32'(w[5][7:0]), 32'hff);
        peer.nbits = 8;
        peer.idx = 0;
        peer.words.push_back(w[7]);
        wr(ta, 32'h10, ok);
        wr(ra, 32'ha0, ok);
        `check(clock_pin_oe, 1'b0)
        peer.drive(8);
        await(0);
        rd(da, ok, 32'(w[7][7:0]), 32'hff);
        end_of_test();
    end
endmodule : sync_serial_receiver_test
bind ssr_receiver ssr_asserts i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_pin_o, .clock_pin_oe,
    .data_pin_oe, .receive_char_flag);
`default_nettype wire
